// >>> src/qei_encoder.sv
// Quadrature encoder output generator: turns shaft step requests into A, B, N.
// Assumes step requests are synchronous to clk; one request per step.
// Summary of operation
// R1 - A and B offset by a quarter period
// R2 - N pulses once per revolution at zero
// R3 - Inverted copies of A, B, N driven
// R4 - Cycles per revolution equal line count
// R5 - Every position step gives one transition
// R6 - Receiver counts steps between A/B edges
// R7 - Receiver may count x2 or x4
// R8 - 2500 lines give 5000 or 10000 counts
// R9 - Edge spacing kept above receiver minimum
// R10 - Receiver derives direction from leading channel
`timescale 1ns/1ps
`default_nettype none
module qei_encoder (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      step_req,
  input  wire logic                      step_cw,
  input  wire logic                      diff_en,
  input  wire logic [qei_pkg::POS_W-1:0] lines,
  output logic                           step_ready,
  output logic [qei_pkg::POS_W-1:0]      line_pos,
  output logic                           a_out,
  output logic                           b_out,
  output logic                           n_out,
  output logic                           a_n_out,
  output logic                           b_n_out,
  output logic                           n_n_out
);
  import qei_pkg::*;

  typedef enum logic [0:0] {QEI_IDLE, QEI_HOLD} qei_state_t;

  qei_state_t           state_q, state_d;
  logic [PHASE_W-1:0]   phase_q, phase_d;
  logic [POS_W-1:0]     pos_q, pos_d;
  logic [GAP_W-1:0]     gap_q, gap_d;
  logic                 a_q, a_d, b_q, b_d, n_q, n_d;
  logic [POS_W-1:0]     last_line;
  logic                 take;

  qei_out_if chan ();

  ////////////////////////////////////////////////////////////////
  // R9 edge spacing guard: requests accepted only after the gap
  assign step_ready = (state_q == QEI_IDLE);
  assign take       = step_req & step_ready;
  // Zero lines would hang the wrap; treat as one line
  assign last_line  = (lines == POS_RST) ? POS_RST : lines - 16'h0001;

  // Next position, phase and gap counter
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    pos_d   = pos_q;
    gap_d   = gap_q;
    case (state_q)
      QEI_IDLE: begin
        if (take) begin
          // R5 one quarter step per request
          phase_d = step_cw ? phase_q + 2'h1 : phase_q - 2'h1;
          // R4 line count steps once per full cycle, wrapping at the line count
          if (step_cw && phase_q == 2'h3) begin
            pos_d = (pos_q >= last_line) ? POS_RST : pos_q + 16'h0001;
          end else if (!step_cw && phase_q == 2'h0) begin
            pos_d = (pos_q == POS_RST) ? last_line : pos_q - 16'h0001;
          end
          state_d = QEI_HOLD;
          gap_d   = GAP_W'(MIN_EDGE_CYC - 1);
        end
      end
      default: begin
        if (gap_q == GAP_RST) begin
          state_d = QEI_IDLE;
        end else begin
          gap_d = gap_q - 8'h01;
        end
      end
    endcase
  end

  // R1 quarter-period offset via gray phase
  always_comb begin
    {a_d, b_d} = qei_gray(phase_d);
    // R2 reference pulse at zero line, phase zero
    n_d        = (pos_d == POS_RST) && (phase_d == PHASE_RST);
  end

  // Register the whole group; channels come straight from flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= QEI_IDLE;
      phase_q <= PHASE_RST;
      pos_q   <= POS_RST;
      gap_q   <= GAP_RST;
      a_q     <= 1'b0;
      b_q     <= 1'b0;
      n_q     <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      pos_q   <= pos_d;
      gap_q   <= gap_d;
      a_q     <= a_d;
      b_q     <= b_d;
      n_q     <= n_d;
    end
  end

  assign line_pos    = pos_q;
  assign chan.chan_a = a_q;
  assign chan.chan_b = b_q;
  assign chan.chan_n = n_q;

  ////////////////////////////////////////////////////////////////
  // R3 output stage with inverted copies
  qei_out_stage u_out (
    .clk     (clk),
    .rstn    (rstn),
    .diff_en (diff_en),
    .chan    (chan),
    .a_out   (a_out),
    .b_out   (b_out),
    .n_out   (n_out),
    .a_n_out (a_n_out),
    .b_n_out (b_n_out),
    .n_n_out (n_n_out)
  );
endmodule : qei_encoder
`default_nettype wire

// >>> src/qei_out_if.sv
// Interface carrying the encoder channel levels to the output stage.
// Assumes the producer drives all fields from flip-flops.
`timescale 1ns/1ps
`default_nettype none
interface qei_out_if;
  logic chan_a;
  logic chan_b;
  logic chan_n;
  modport src (output chan_a, output chan_b, output chan_n);
  modport dst (input chan_a, input chan_b, input chan_n);
endinterface : qei_out_if
`default_nettype wire

// >>> src/qei_out_stage.sv
// Output stage: true and inverted copies of the three channels.
// Assumes input levels come from flip-flops; copies are registered.
`timescale 1ns/1ps
`default_nettype none
module qei_out_stage (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic diff_en,
  qei_out_if.dst    chan,
  output logic      a_out,
  output logic      b_out,
  output logic      n_out,
  output logic      a_n_out,
  output logic      b_n_out,
  output logic      n_n_out
);
  import qei_pkg::*;
  logic [5:0] pins_d;
  logic [5:0] pins_q;

  ////////////////////////////////////////////////////////////////
  // R3 inverted channel copies; low when the single-ended variant
  always_comb begin
    pins_d = {chan.chan_a, chan.chan_b, chan.chan_n,
              diff_en & ~chan.chan_a, diff_en & ~chan.chan_b, diff_en & ~chan.chan_n};
  end

  // Registered so true and inverted pins switch on the same edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_q <= 6'h00;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign {a_out, b_out, n_out, a_n_out, b_n_out, n_n_out} = pins_q;
endmodule : qei_out_stage
`default_nettype wire

// >>> src/qei_pkg.sv
// Package for the quadrature encoder output generator.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
package qei_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned LINES_DEFAULT  = 2500;
  localparam int unsigned POS_W          = 16;
  localparam int unsigned PHASE_W        = 2;
  localparam int unsigned MIN_EDGE_NS    = 100;
  localparam int unsigned MIN_EDGE_CYC   = (MIN_EDGE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_W          = 8;
  localparam logic [PHASE_W-1:0] PHASE_RST = 2'h0;
  localparam logic [POS_W-1:0]   POS_RST   = 16'h0000;
  localparam logic [GAP_W-1:0]   GAP_RST   = 8'h00;

  // Gray sequence of the two channels, one entry per quarter period
  function automatic logic [1:0] qei_gray(input logic [PHASE_W-1:0] ph);
    case (ph)
      2'h0:    qei_gray = 2'h0;
      2'h1:    qei_gray = 2'h1;
      2'h2:    qei_gray = 2'h3;
      default: qei_gray = 2'h2;
    endcase
  endfunction : qei_gray
endpackage : qei_pkg

// >>> verification/qei_monitor.sv
// Port checker for the encoder generator.
// Assumes a bind onto qei_encoder.
`timescale 1ns/1ps
`default_nettype none
module qei_monitor import qei_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic step_req,
  input wire logic step_cw,
  input wire logic diff_en,
  input wire logic [POS_W-1:0] lines,
  input wire logic step_ready,
  input wire logic [POS_W-1:0] line_pos,
  input wire logic a_out,
  input wire logic b_out,
  input wire logic n_out,
  input wire logic a_n_out,
  input wire logic b_n_out,
  input wire logic n_n_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic take, dir_q;
  logic [1:0] ab;
  logic [POS_W-1:0] up, dn;
  // Next line index either way, wrapping at the line count
  assign take = step_req && step_ready;
  assign ab = {a_out, b_out};
  assign up = (line_pos + 16'h1 == lines) ? 16'h0 : line_pos + 16'h1;
  assign dn = (line_pos == 16'h0) ? lines - 16'h1 : line_pos - 16'h1;
  // Direction of the last step taken
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) dir_q <= 1'b0;
    else if (take) dir_q <= step_cw;
  // Ready stays low for ten sampled edges after a take, then returns
  sequence busy_gap; (!step_ready)[*8] ##1 (!step_ready)[*2]; endsequence
  gap_ready_a: assert property (take |=> busy_gap ##1 step_ready) else $error("gap");
  // A channel edge is followed by at least nine quiet edges
  edge_space_a: assert property ($changed(ab) |=> $stable(ab)[*8] ##1 $stable(ab)) else $error("close");
  one_chan_a: assert property ($changed(ab) |-> $countones(ab ^ $past(ab)) == 1) else $error("two");
  lead_dir_a: assert property ($changed(ab) |-> (ab ^ $past(ab)) ==
    ((($past(a_out) == $past(b_out)) ^ dir_q) ? 2'h2 : 2'h1)) else $error("lead");
  diff_copy_a: assert property ($past(rstn, 2) |-> {a_n_out, b_n_out, n_n_out} ==
    ({3{$past(diff_en)}} & ~{a_out, b_out, n_out})) else $error("copy");
  zero_mark_a: assert property ($past(rstn, 3) && $past(step_ready) && step_ready |->
    n_out == (line_pos == 16'h0 && ab == 2'h0)) else $error("zero");
  wrap_up_a: assert property (take && step_cw && ab == 2'h2 |=> line_pos == $past(up)) else $error("up");
  wrap_dn_a: assert property (take && !step_cw && ab == 2'h0 |=> line_pos == $past(dn)) else $error("dn");
endmodule : qei_monitor
`default_nettype wire

// >>> verification/qei_rx_model.sv
// Receiver model: counts encoder edges at x4 and x2.
// Assumes A and B change only on clk edges.
`timescale 1ns/1ps
`default_nettype none
module qei_rx_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic chan_a,
  input wire logic chan_b,
  output int       cnt4,
  output int       cnt2
);
  logic pa, pb;
  // x4: one count per A or B edge; x2: one count per A edge; sign from lead
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pa <= 1'b0; pb <= 1'b0; cnt4 <= 0; cnt2 <= 0;
    end else begin
      if (chan_a != pa || chan_b != pb) cnt4 <= cnt4 + (((chan_a != pa) == (pa != pb)) ? 1 : -1);
      if (chan_a != pa) cnt2 <= cnt2 + ((chan_a == chan_b) ? 1 : -1);
      pa <= chan_a; pb <= chan_b;
    end
  end
endmodule : qei_rx_model
`default_nettype wire

// >>> verification/test_qei_encoder.sv
// Bench for the encoder generator with a counting receiver.
// Assumes the monitor is bound below.
`timescale 1ns/1ps
`default_nettype none
module test_qei_encoder;
  import qei_pkg::*;
  logic clk = 0, rstn = 0, step_req = 0, step_cw = 0, diff_en = 0;
  logic [POS_W-1:0] lines = 16'h0003, line_pos;
  logic step_ready, a_out, b_out, n_out, a_n_out, b_n_out, n_n_out;
  int err_total = 0, cmp_count = 0, e4 = 0, c4, c2, k;
  always #5 clk = ~clk;
  qei_encoder u_dut (.clk, .rstn, .step_req, .step_cw, .diff_en, .lines, .step_ready,
    .line_pos, .a_out, .b_out, .n_out, .a_n_out, .b_n_out, .n_n_out);
  qei_rx_model u_rx (.clk, .rstn, .chan_a(a_out), .chan_b(b_out), .cnt4(c4), .cnt2(c2));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // Line index expected after s net quarter steps
  function automatic logic [31:0] pos_of(int s);
    int f;
    f = (s >>> 2) % int'(lines);
    return (f < 0) ? f + int'(lines) : f;
  endfunction : pos_of
  // One step; waits out the gap, a lost wait counts as a mismatch
  task stp(input logic d);
    k = 0;
    while (step_ready !== 1'b1 && k < 40) begin @(posedge clk); #1; k++; end
    if (k == 40) err_total++;
    step_req = 1; step_cw = d; e4 += d ? 1 : -1;
    @(posedge clk); #1; step_req = 0;
  endtask : stp
  task settle(input string name);
    repeat (12) @(posedge clk);
    #1;
    chk(c4, e4);
    chk(32'(line_pos), pos_of(e4));
    chk(32'({a_n_out, b_n_out, n_n_out}), 32'({3{diff_en}} & ~{a_out, b_out, n_out}));
    $display("done %s", name);
  endtask : settle
  initial begin
    k = $urandom(32'h6ED2);
    lines = 16'($urandom_range(6, 3));
    repeat (12) @(posedge clk);
    #1 rstn = 1;
    repeat (4 * lines) stp(1'b1);
    settle("revolution");
    chk(c2, 2 * lines);
    chk(32'(n_out), 1);
    // Held request must be paced by the gap
    step_req = 1; step_cw = 0;
    repeat (40) @(posedge clk);
    #1 step_req = 0; e4 -= 4;
    settle("held");
    repeat (60) begin diff_en = 1'($urandom); stp(1'($urandom)); end
    settle("random");
    // Mid-run reset brings the shaft back to line zero, phase zero
    rstn = 0; e4 = 0;
    repeat (3) @(posedge clk);
    #1 rstn = 1;
    chk(32'({a_out, b_out, line_pos}), 32'h0);
    stp(1'b0);
    settle("reset");
    chk(32'(n_out), 32'h0);
    print_verdict;
  end
  // Watchdog well beyond the expected run
  initial begin #50000; err_total++; print_verdict; end
endmodule : test_qei_encoder
bind qei_encoder qei_monitor u_mon (.clk, .rstn, .step_req, .step_cw, .diff_en, .lines,
  .step_ready, .line_pos, .a_out, .b_out, .n_out, .a_n_out, .b_n_out, .n_n_out);
`default_nettype wire
